//--- design/crc_engine_pkg.sv
// Purpose: Shared constants and types for the programmable checksum engine
// Assumes: 32-bit register bus with byte addresses, one clock, synchronous reset
// Notes: Register map, mode-field layout, polynomials and write-size codes
package crc_engine_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int INPUT_FIFO_DEPTH = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] START_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] DATA_ADDR = 12'h008;

  // Mode register layout: bits 5..0 are live, 31..6 read as zero
  localparam int CONFIG_W = 6;
  localparam int POLY_WIDE_BIT = 1;
  localparam logic [DATA_W-1:0] START_RESET = 32'h0000FFFF;
  localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000FFFF;
  localparam logic [CONFIG_W-1:0] CONFIG_RESET = 6'h00;
  localparam logic [DATA_W-1:0] LOW16_MASK = 32'h0000FFFF;

  // Generators, normal (MSB-first) form without the top term
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;
  localparam logic [31:0] POLY_CRC32 = 32'h04C11DB7;
  localparam logic [1:0] SEL_CCITT = 2'h0;

  // Write size codes that travel with each data word
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_HALF = 3'h2;
  localparam logic [2:0] BYTES_WORD = 3'h4;

  typedef struct packed {
    logic resultInvert;
    logic resultBitReverse;
    logic inputInvert;
    logic inputBitReverse;
    logic [1:0] polynomialSelect;
  } config_t;

  typedef struct packed {
    logic [1:0] size;
    logic [DATA_W-1:0] data;
  } in_word_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_WAIT = 1'b1
  } read_state_t;

endpackage : crc_engine_pkg

//--- design/programmable_crc_engine.sv
// Purpose: Memory-mapped checksum engine with three generators and a data FIFO
// Assumes: Synchronous inputs on mclk, rst synchronous active high
// Notes: Data words queue in a 16-entry FIFO and drain one byte per cycle
//
// What this block does
// RULE1: Mode bits 1:0 pick the generator
// RULE2: CCITT, CRC-16 and CRC-32 generators implemented
// RULE3: Mode bit 2 reverses input bits per byte
// RULE4: Mode bit 3 complements input data
// RULE5: Mode bit 4 reverses result bit order
// RULE6: Mode bit 5 complements the read result
// RULE7: Start-value write loads preprocessed running checksum
// RULE8: Start-value write abandons any pending calculation
// RULE9: Result read waits until all bytes done
// RULE10: Offset 8 read gives postprocessed result, unaltered
// RULE11: Offset 8 write feeds data; direction decides
// RULE12: Data accepts 8/16/32-bit writes back to back
// RULE13: One byte processed per clock cycle
// RULE14: Software sets CCITT with mode 0, start FFFF
// RULE15: Software sets CRC-16 with mode 15, start 0
// RULE16: Software sets CRC-32 with mode 36, start all-ones
// RULE17: Word bytes processed least significant first
// RULE18: Mode bits 31:6 ignored, read zero
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps

module input_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("input_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] writePtr;
    logic [PW-1:0] readPtr;
    logic [CW-1:0] count;
    logic notFull;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = inValid && s.notFull;
    pop = outReady && (s.count != '0);
    if (flush) begin
      // Stale words must not survive a reload of the running value
      next_s.writePtr = '0;
      next_s.readPtr = '0;
      next_s.count = '0;
      next_s.notFull = 1'b1;
    end else begin
      if (push) begin
        next_s.mem[s.writePtr] = inData;
        next_s.writePtr = s.writePtr + PW'(1);
      end
      if (pop) begin
        next_s.readPtr = s.readPtr + PW'(1);
      end
      next_s.count = s.count + CW'(push) - CW'(pop);
      next_s.notFull = (next_s.count != FULL_COUNT);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.notFull <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign inReady = s.notFull;
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.readPtr];

endmodule : input_fifo

module programmable_crc_engine
  import crc_engine_pkg::*;
#(
  parameter int FIFO_DEPTH = INPUT_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busWriteData,
  input wire logic [1:0] busWriteSize,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [DATA_W-1:0] busReadData,
  output logic readWait,
  output logic inputReady
);

  typedef struct packed {
    config_t cfg;
    logic [DATA_W-1:0] startValue;
    logic [DATA_W-1:0] crc;
    logic [DATA_W-1:0] word;
    logic [2:0] bytesLeft;
    read_state_t rdState;
    logic [DATA_W-1:0] readData;
    logic readWait;
  } state_t;

  state_t s;
  state_t next_s;
  in_word_t fifoIn;
  in_word_t fifoOut;
  logic fifoPush;
  logic fifoValid;
  logic fifoPop;
  logic fifoFlush;
  logic fifoReady;
  logic engineIdle;

  function automatic logic [DATA_W-1:0] reverseEachByte(input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[(i / 8) * 8 + 7 - (i % 8)] = x[i];
    end
    return r;
  endfunction : reverseEachByte

  function automatic logic [DATA_W-1:0] reverseAll(input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[DATA_W - 1 - i] = x[i];
    end
    return r;
  endfunction : reverseAll

  // Same preprocessing serves data words and start values
  function automatic logic [DATA_W-1:0] preprocess(input config_t c,
                                                   input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    r = c.inputBitReverse ? reverseEachByte(x) : x; // RULE3
    r = c.inputInvert ? ~r : r; // RULE4
    return r;
  endfunction : preprocess

  // Eight MSB-first shift steps; 16-bit generators live in the low half
  function automatic logic [DATA_W-1:0] crcByte(input logic [DATA_W-1:0] crc,
                                                input logic [7:0] b,
                                                input logic [1:0] sel);
    logic [DATA_W-1:0] r;
    logic [15:0] r16;
    logic fb;
    r = crc;
    r16 = crc[15:0];
    for (int i = 7; i >= 0; i--) begin
      if (sel[POLY_WIDE_BIT]) begin // RULE1
        fb = r[31] ^ b[i];
        r = {r[30:0], 1'b0} ^ (fb ? POLY_CRC32 : '0); // RULE2
      end else begin
        fb = r16[15] ^ b[i];
        r16 = {r16[14:0], 1'b0} ^ (fb ? ((sel == SEL_CCITT) ? POLY_CCITT : POLY_CRC16) : '0); // RULE2
      end
    end
    return sel[POLY_WIDE_BIT] ? r : {16'h0000, r16};
  endfunction : crcByte

  function automatic logic [2:0] byteCount(input logic [1:0] size);
    logic [2:0] n;
    n = BYTES_WORD;
    if (size == SIZE_BYTE) begin
      n = BYTES_BYTE;
    end else if (size == SIZE_HALF) begin
      n = BYTES_HALF;
    end
    return n; // RULE12
  endfunction : byteCount

  function automatic logic [DATA_W-1:0] present(input config_t c,
                                                input logic [DATA_W-1:0] crc);
    logic [DATA_W-1:0] r;
    logic wide;
    logic [DATA_W-1:0] flipped;
    wide = c.polynomialSelect[POLY_WIDE_BIT];
    r = wide ? crc : (crc & LOW16_MASK);
    if (c.resultBitReverse) begin // RULE5
      // A 16-bit sum lands in the upper half once flipped, so bring it back down
      flipped = reverseAll(r);
      r = wide ? flipped : {16'h0000, flipped[31:16]};
    end
    if (c.resultInvert) begin // RULE6
      r = wide ? ~r : (r ^ LOW16_MASK);
    end
    return r;
  endfunction : present

  assign fifoIn = '{size: busWriteSize, data: preprocess(s.cfg, busWriteData)};
  assign fifoPush = busWrite && (busAddr == DATA_ADDR); // RULE11
  assign engineIdle = (s.bytesLeft == '0) && !fifoValid;

  always_comb begin
    next_s = s;
    fifoPop = 1'b0;
    fifoFlush = 1'b0;
    next_s.readData = '0;
    if (busWrite && busAddr == CONFIG_ADDR) begin
      next_s.cfg = busWriteData[CONFIG_W-1:0]; // RULE18
    end
    if (busWrite && busAddr == START_ADDR) begin
      next_s.startValue = busWriteData;
      next_s.crc = preprocess(s.cfg, busWriteData); // RULE7
      next_s.bytesLeft = '0; // RULE8
      fifoFlush = 1'b1; // RULE8
    end else begin
      if (s.bytesLeft != '0) begin
        next_s.crc = crcByte(s.crc, s.word[7:0], s.cfg.polynomialSelect); // RULE13
        next_s.word = s.word >> 8; // RULE17
        next_s.bytesLeft = s.bytesLeft - 3'h1;
      end
      // Reload on the last byte so back-to-back words lose no cycle
      if (fifoValid && s.bytesLeft <= 3'h1) begin
        fifoPop = 1'b1;
        next_s.word = fifoOut.data;
        next_s.bytesLeft = byteCount(fifoOut.size); // RULE13
      end
    end
    unique case (s.rdState)
      RD_IDLE: begin
        if (busRead) begin
          if (busAddr == CONFIG_ADDR) begin
            next_s.readData = {{(DATA_W - CONFIG_W){1'b0}}, s.cfg}; // RULE18
          end else if (busAddr == START_ADDR) begin
            next_s.readData = s.startValue;
          end else if (busAddr == DATA_ADDR) begin
            if (engineIdle) begin
              next_s.readData = present(s.cfg, s.crc); // RULE10
            end else begin
              next_s.rdState = RD_WAIT; // RULE9
            end
          end
        end
      end
      RD_WAIT: begin
        if (engineIdle) begin
          next_s.readData = present(s.cfg, s.crc); // RULE9
          next_s.rdState = RD_IDLE;
        end
      end
    endcase
    next_s.readWait = (next_s.rdState == RD_WAIT);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= CONFIG_RESET;
      s.startValue <= START_RESET;
      s.crc <= RESULT_RESET;
      s.rdState <= RD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  input_fifo #(
    .WIDTH($bits(in_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_input_fifo (
    .mclk(mclk),
    .rst(rst),
    .flush(fifoFlush),
    .inValid(fifoPush),
    .inData(fifoIn),
    .inReady(fifoReady),
    .outValid(fifoValid),
    .outData(fifoOut),
    .outReady(fifoPop)
  );

  assign busReadData = s.readData;
  assign readWait = s.readWait;
  assign inputReady = fifoReady;

endmodule : programmable_crc_engine

//--- sim/crc_engine_sva.sv
// Purpose: Port assertions for the checksum engine
// Assumes: One clock, rst synchronous
// Notes: Bound to every engine instance
`timescale 1ns/100ps
module crc_engine_sva
  import crc_engine_pkg::*;
#(
  parameter int FIFO_DEPTH = INPUT_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [DATA_W-1:0] busWriteData,
  input wire logic [1:0] busWriteSize,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [DATA_W-1:0] busReadData,
  input wire logic readWait,
  input wire logic inputReady
);
  // A full queue plus the word in flight, with slack for the pop latency
  localparam int WAIT_MAX = 4 * FIFO_DEPTH + 8;
  int waitCount;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) begin
    if (rst || !readWait) begin
      waitCount <= 0;
    end else begin
      waitCount <= waitCount + 1;
    end
  end
  AST_QUIET_DATA: assert property (!$past(busRead) && !$fell(readWait) |-> busReadData == '0)
    else $error("read data outside an answer cycle");
  AST_CONFIG_RESERVED: assert property (busRead && busAddr == CONFIG_ADDR && !readWait
    |=> busReadData[31:6] == '0) else $error("reserved mode bits read nonzero");
  AST_WAIT_ONLY_RESULT: assert property (busRead && busAddr != DATA_ADDR && !readWait
    |=> !readWait) else $error("wait on a non-result read");
  AST_WAIT_CAUSE: assert property ($rose(readWait) |-> $past(busRead)
    && $past(busAddr) == DATA_ADDR) else $error("wait without a result read");
  AST_WAIT_BOUNDED: assert property (waitCount <= WAIT_MAX)
    else $error("result wait too long");
  AST_START_FLUSH: assert property (busWrite && busAddr == START_ADDR |-> ##[1:2] inputReady)
    else $error("queue not flushed by start load");
  AST_UNMAPPED_ZERO: assert property (busRead && busAddr > DATA_ADDR && !readWait
    |=> busReadData == '0) else $error("unmapped read nonzero");
  AST_FULL_CAUSE: assert property ($fell(inputReady) |-> $past(busWrite) || $past(busWrite, 2))
    else $error("queue full without a write");
  CVR_WAIT: cover property ($rose(readWait));
  CVR_FULL: cover property ($fell(inputReady));
  CVR_LOAD_FULL: cover property (busWrite && busAddr == START_ADDR && !inputReady);
endmodule : crc_engine_sva

bind programmable_crc_engine crc_engine_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_crc_engine_sva (
  .mclk(mclk), .rst(rst), .busAddr(busAddr), .busWriteData(busWriteData),
  .busWriteSize(busWriteSize), .busWrite(busWrite), .busRead(busRead),
  .busReadData(busReadData), .readWait(readWait), .inputReady(inputReady));

//--- sim/bus_host.sv
// Purpose: Processor-side master of the engine register port
// Assumes: Tasks are entered just after a rising edge of mclk
// Notes: A write leaves its strobe up so writes run back to back; idle drops it
`timescale 1ns/100ps
module bus_host
  import crc_engine_pkg::*;
(
  input wire logic mclk,
  output logic [ADDR_W-1:0] busAddr,
  output logic [DATA_W-1:0] busWriteData,
  output logic [1:0] busWriteSize,
  output logic busWrite,
  output logic busRead,
  input wire logic [DATA_W-1:0] busReadData,
  input wire logic readWait
);
  initial begin
    busAddr = '0;
    busWriteData = '0;
    busWriteSize = '0;
    busWrite = 1'b0;
    busRead = 1'b0;
  end
  task automatic req(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [1:0] s);
    busWrite <= w;
    busRead <= r;
    busAddr <= a;
    busWriteData <= d;
    busWriteSize <= s;
    @(posedge mclk);
  endtask : req
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] s);
    req(1'b1, 1'b0, a, d, s);
  endtask : wr
  // Released data lines show the inverse so stale values never match
  task automatic idle();
    req(1'b0, 1'b0, busAddr, ~busWriteData, busWriteSize);
  endtask : idle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    req(1'b0, 1'b1, a, ~busWriteData, 2'h0);
    busRead <= 1'b0;
    busWriteData <= ~busWriteData;
    // Look just after the edge, once the answer register has settled
    #1;
    n = 0;
    while (readWait === 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    d = busReadData;
  endtask : rd
endmodule : bus_host

//--- sim/programmable_crc_engine_tb_top.sv
// Purpose: Self-checking bench for the checksum engine
// Assumes: Shallow queue so refusal comes quickly
// Notes: Sums are check values of the string 123456789; all but the last, 8D94, are standard ones
`timescale 1ns/100ps
module programmable_crc_engine_tb_top
  import crc_engine_pkg::*;
;
  localparam logic [31:0] MODES [6] = '{32'h00, 32'h15, 32'h36, 32'h37, 32'h28, 32'h18};
  localparam logic [31:0] SEEDS [6] = '{32'hFFFF, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0};
  localparam logic [31:0] SUMS [6] = '{32'h29B1, 32'hBB3D, 32'hCBF43926, 32'hCBF43926,
                                       32'hD64E, 32'h8D94};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busWriteData;
  logic [DATA_W-1:0] busReadData;
  logic [1:0] busWriteSize;
  logic busWrite;
  logic busRead;
  logic readWait;
  logic inputReady;
  int err_count = 0;
  int check_count = 0;
  always #5 mclk = ~mclk;
  programmable_crc_engine #(.FIFO_DEPTH(4)) u_programmable_crc_engine (
    .mclk(mclk), .rst(rst), .busAddr(busAddr), .busWriteData(busWriteData),
    .busWriteSize(busWriteSize), .busWrite(busWrite), .busRead(busRead),
    .busReadData(busReadData), .readWait(readWait), .inputReady(inputReady));
  bus_host u_bus_host (
    .mclk(mclk), .busAddr(busAddr), .busWriteData(busWriteData), .busWriteSize(busWriteSize),
    .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData), .readWait(readWait));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic test_reset();
    logic [31:0] d;
    u_bus_host.rd(START_ADDR, d);
    chk("start reset", 32'h0000FFFF, d);
    u_bus_host.rd(DATA_ADDR, d);
    chk("sum reset", 32'h0000FFFF, d);
    u_bus_host.wr(12'h00C, 32'h12345678, 2'h2);
    u_bus_host.wr(CONFIG_ADDR, 32'hFFFFFFC0, 2'h2);
    u_bus_host.rd(12'h00C, d);
    chk("unmapped", 32'h0, d);
    u_bus_host.rd(CONFIG_ADDR, d);
    chk("mode reserved", 32'h0, d);
  endtask : test_reset
  task automatic test_modes();
    logic [31:0] d;
    logic [31:0] inv;
    for (int i = 0; i < 6; i++) begin
      inv = (i >= 4) ? 32'hFFFFFFFF : 32'h0;
      u_bus_host.wr(CONFIG_ADDR, MODES[i], 2'h2);
      u_bus_host.wr(START_ADDR, SEEDS[i], 2'h2);
      u_bus_host.wr(DATA_ADDR, 32'h34333231 ^ inv, 2'h2);
      u_bus_host.wr(DATA_ADDR, 32'hBBBB3635 ^ inv, 2'h1);
      u_bus_host.wr(DATA_ADDR, 32'hCCCC3837 ^ inv, 2'h1);
      u_bus_host.wr(DATA_ADDR, 32'hAAAAAA39 ^ inv, 2'h0);
      u_bus_host.rd(DATA_ADDR, d);
      chk("sum", SUMS[i], d);
      u_bus_host.rd(DATA_ADDR, d);
      chk("sum again", SUMS[i], d);
      u_bus_host.rd(CONFIG_ADDR, d);
      chk("mode", MODES[i], d);
    end
  endtask : test_modes
  task automatic test_abandon();
    logic [31:0] d;
    logic full;
    full = 1'b0;
    u_bus_host.wr(CONFIG_ADDR, 32'h16, 2'h2);
    for (int i = 0; i < 8; i++) begin
      u_bus_host.wr(DATA_ADDR, 32'h5A5A5A5A, 2'h2);
      #1;
      if (inputReady === 1'b0) begin
        full = 1'b1;
      end
    end
    chk("queue full", 32'h1, {31'h0, full});
    u_bus_host.wr(START_ADDR, 32'h000000F0, 2'h2);
    u_bus_host.rd(DATA_ADDR, d);
    chk("abandoned sum", 32'hF0000000, d);
    chk("ready after load", 32'h1, {31'h0, inputReady});
  endtask : test_abandon
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    test_reset();
    test_modes();
    test_abandon();
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule : programmable_crc_engine_tb_top
